// *** duart_host_pkg.sv ***
// Package with constants for the dual UART host select and status block
package duart_host_pkg;
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          RESET_MIN_NS      = 40;
   localparam int          RESET_MIN_CYCLES  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          FIFO_CTRL_EN_BIT  = 0;
   localparam int          FIFO_CTRL_BLK_BIT = 3;
   localparam int          LSR_TX_ROOM_BIT   = 5;
   localparam int          LSR_TX_EMPTY_BIT  = 6;
   localparam int          FIFO_DEPTH        = 16;
   localparam int          CNT_W             = 5;
   localparam logic [7:0]  DIV_LOW_RST       = 8'h01;
   localparam logic [7:0]  DIV_HIGH_RST      = 8'h00;
   localparam logic [3:0]  DIV_FRAC_RST      = 4'h0;
   localparam logic [7:0]  FIFO_CTRL_RST     = 8'h00;
   localparam logic [7:0]  IDENT_CODE_VAL    = 8'h5A; // Arbitrary value
   localparam logic [7:0]  REVISION_VAL      = 8'hA5; // Arbitrary value
   typedef enum logic [1:0] {SEL_NONE, SEL_A, SEL_B, SEL_BOTH} chan_sel_t;
endpackage

// *** chan_status.sv ***
// Per-channel ready, interrupt and line status pin logic
`timescale 1ns/100ps
`default_nettype none
module chan_status
   import duart_host_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Configuration
   input  wire logic [7:0]       fifo_ctrl_i,
   input  wire logic [CNT_W-1:0] tx_trig_i,
   // Status
   input  wire logic [CNT_W-1:0] rx_count_i,
   input  wire logic [CNT_W-1:0] tx_count_i,
   input  wire logic             rx_trig_hit_i,
   input  wire logic             rx_timeout_i,
   input  wire logic             tx_shift_busy_i,
   // Pins
   output logic                  rx_block_ready_n_o,
   output logic                  tx_block_ready_n_o,
   output logic                  tx_irq_o,
   output logic [7:0]            line_status_o
);
   logic fifo_en;
   logic blk_mode;
   assign fifo_en  = fifo_ctrl_i[FIFO_CTRL_EN_BIT];
   assign blk_mode = fifo_en & fifo_ctrl_i[FIFO_CTRL_BLK_BIT];

   // Receive ready: single-character or block paced
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_block_ready_n_o <= 1'b1;
      end else if (blk_mode) begin
         if (rx_trig_hit_i || rx_timeout_i)
            rx_block_ready_n_o <= 1'b0;
         else if (rx_count_i == '0)
            rx_block_ready_n_o <= 1'b1;
      end else begin
         rx_block_ready_n_o <= (rx_count_i == '0);
      end
   end

   // Transmit ready
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_block_ready_n_o <= 1'b0;
      end else if (blk_mode) begin
         tx_block_ready_n_o <= (tx_count_i == CNT_W'(FIFO_DEPTH));
      end else if (fifo_en) begin
         tx_block_ready_n_o <= (tx_count_i != '0);
      end else begin
         tx_block_ready_n_o <= (tx_count_i != '0);
      end
   end

   // Transmit interrupt and line status
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_irq_o      <= 1'b0;
         line_status_o <= 8'h60;
      end else begin
         tx_irq_o <= fifo_en ? (tx_count_i <= tx_trig_i) : (tx_count_i == '0);
         line_status_o <= '0;
         line_status_o[LSR_TX_ROOM_BIT] <= fifo_en ? (tx_count_i != CNT_W'(FIFO_DEPTH))
                                                   : (tx_count_i == '0);
         line_status_o[LSR_TX_EMPTY_BIT] <= (tx_count_i == '0) && !tx_shift_busy_i;
      end
   end
endmodule
`default_nettype wire

// *** duart_host_select.sv ***
// Top: bus style, channel select, reset polarity, identity readout
`timescale 1ns/100ps
`default_nettype none
module duart_host_select
   import duart_host_pkg::*;
(
   // Clock and raw reset pin
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Bus style and selects (pins)
   input  wire logic             bus_style_i,
   input  wire logic             chan_a_select_n_i,
   input  wire logic             chan_b_select_n_i,
   input  wire logic             channel_address_bit_i,
   input  wire logic             rd_i,
   // Channel A configuration and status
   input  wire logic [7:0]       a_div_low_i,
   input  wire logic [7:0]       a_div_high_i,
   input  wire logic [7:0]       a_fifo_ctrl_i,
   input  wire logic [CNT_W-1:0] a_tx_trig_i,
   input  wire logic [CNT_W-1:0] a_rx_count_i,
   input  wire logic [CNT_W-1:0] a_tx_count_i,
   input  wire logic             a_rx_trig_hit_i,
   input  wire logic             a_rx_timeout_i,
   input  wire logic             a_tx_busy_i,
   // Channel B configuration and status
   input  wire logic [7:0]       b_div_low_i,
   input  wire logic [7:0]       b_div_high_i,
   input  wire logic [7:0]       b_fifo_ctrl_i,
   input  wire logic [CNT_W-1:0] b_tx_trig_i,
   input  wire logic [CNT_W-1:0] b_rx_count_i,
   input  wire logic [CNT_W-1:0] b_tx_count_i,
   input  wire logic             b_rx_trig_hit_i,
   input  wire logic             b_rx_timeout_i,
   input  wire logic             b_tx_busy_i,
   // Decode and identity outputs
   output logic                  chip_reset_o,
   output logic                  sel_a_o,
   output logic                  sel_b_o,
   output logic                  ident_visible_o,
   output logic [7:0]            ident_code_reg_o,
   output logic [7:0]            revision_reg_o,
   // Channel pins
   output logic                  a_rx_block_ready_n_o,
   output logic                  a_tx_block_ready_n_o,
   output logic                  chan_a_irq_o,
   output logic [7:0]            a_line_status_o,
   output logic                  b_rx_block_ready_n_o,
   output logic                  b_tx_block_ready_n_o,
   output logic                  chan_b_irq_o,
   output logic [7:0]            b_line_status_o
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] style_s_q, csa_s_q, csb_s_q, addr_s_q, rd_s_q, rst_s_q;
   always_ff @(posedge clk_i) begin
      style_s_q <= {style_s_q[0], bus_style_i};
      csa_s_q   <= {csa_s_q[0], chan_a_select_n_i};
      csb_s_q   <= {csb_s_q[0], chan_b_select_n_i};
      addr_s_q  <= {addr_s_q[0], channel_address_bit_i};
      rd_s_q    <= {rd_s_q[0], rd_i};
      rst_s_q   <= {rst_s_q[0], rst_i};
   end

   // ------------------------------------------------------------
   // Reset pin qualification
   // ------------------------------------------------------------
   logic       strobe_mode;
   logic       rst_active;
   logic [2:0] rst_cnt_q;
   assign strobe_mode = style_s_q[1];
   assign rst_active  = strobe_mode ? rst_s_q[1] : !rst_s_q[1];

   always_ff @(posedge clk_i) begin
      if (!rst_active)
         rst_cnt_q <= '0;
      else if (rst_cnt_q != 3'(RESET_MIN_CYCLES))
         rst_cnt_q <= rst_cnt_q + 3'h1;
   end

   always_ff @(posedge clk_i) begin
      chip_reset_o <= rst_active && (rst_cnt_q == 3'(RESET_MIN_CYCLES));
   end

   // ------------------------------------------------------------
   // Channel decode
   // ------------------------------------------------------------
   function automatic chan_sel_t decode(input logic strobe, input logic csa_n,
                                        input logic csb_n, input logic addr);
      chan_sel_t s;
      s = SEL_NONE;
      if (strobe) begin
         unique case ({csa_n, csb_n})
            2'b11: s = SEL_NONE;
            2'b01: s = SEL_A;
            2'b10: s = SEL_B;
            2'b00: s = SEL_BOTH;
         endcase
      end else if (!csa_n) begin
         s = addr ? SEL_B : SEL_A;
      end
      return s;
   endfunction

   chan_sel_t sel;
   assign sel = decode(strobe_mode, csa_s_q[1], csb_s_q[1], addr_s_q[1]);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_a_o <= 1'b0;
         sel_b_o <= 1'b0;
      end else begin
         // Dual read is the host's fault; only channel A answers it
         sel_a_o <= (sel == SEL_A) || (sel == SEL_BOTH);
         sel_b_o <= (sel == SEL_B) || (sel == SEL_BOTH && !rd_s_q[1]);
      end
   end

   // ------------------------------------------------------------
   // Identification readout
   // ------------------------------------------------------------
   logic a_zero, b_zero;
   assign a_zero = (a_div_low_i == 8'h00) && (a_div_high_i == 8'h00);
   assign b_zero = (b_div_low_i == 8'h00) && (b_div_high_i == 8'h00);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ident_visible_o  <= 1'b0;
         ident_code_reg_o <= 8'h00;
         revision_reg_o   <= 8'h00;
      end else begin
         ident_visible_o  <= (sel_b_o ? b_zero : a_zero);
         ident_code_reg_o <= (sel_b_o ? b_zero : a_zero) ? IDENT_CODE_VAL : 8'h00;
         revision_reg_o   <= (sel_b_o ? b_zero : a_zero) ? REVISION_VAL : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Channel status
   // ------------------------------------------------------------
   chan_status u_stat_a (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .fifo_ctrl_i        (a_fifo_ctrl_i),
      .tx_trig_i          (a_tx_trig_i),
      .rx_count_i         (a_rx_count_i),
      .tx_count_i         (a_tx_count_i),
      .rx_trig_hit_i      (a_rx_trig_hit_i),
      .rx_timeout_i       (a_rx_timeout_i),
      .tx_shift_busy_i    (a_tx_busy_i),
      .rx_block_ready_n_o (a_rx_block_ready_n_o),
      .tx_block_ready_n_o (a_tx_block_ready_n_o),
      .tx_irq_o           (chan_a_irq_o),
      .line_status_o      (a_line_status_o)
   );

   chan_status u_stat_b (
      .clk_i              (clk_i),
      .rst_i              (rst_i),
      .fifo_ctrl_i        (b_fifo_ctrl_i),
      .tx_trig_i          (b_tx_trig_i),
      .rx_count_i         (b_rx_count_i),
      .tx_count_i         (b_tx_count_i),
      .rx_trig_hit_i      (b_rx_trig_hit_i),
      .rx_timeout_i       (b_rx_timeout_i),
      .tx_shift_busy_i    (b_tx_busy_i),
      .rx_block_ready_n_o (b_rx_block_ready_n_o),
      .tx_block_ready_n_o (b_tx_block_ready_n_o),
      .tx_irq_o           (chan_b_irq_o),
      .line_status_o      (b_line_status_o)
   );
endmodule
`default_nettype wire

// *** duart_host_properties.sv ***
// Checker for select, transmit ready, interrupt and line status pins
`timescale 1ns/100ps
`default_nettype none
module duart_host_checker
   import duart_host_pkg::*;
(
   // Pins and configuration
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             bus_style_i,
   input wire logic             chan_a_select_n_i,
   input wire logic             chan_b_select_n_i,
   input wire logic             channel_address_bit_i,
   input wire logic [7:0]       a_fifo_ctrl_i,
   input wire logic [CNT_W-1:0] a_tx_trig_i,
   input wire logic [CNT_W-1:0] a_tx_count_i,
   input wire logic             a_tx_busy_i,
   input wire logic [CNT_W-1:0] a_rx_count_i,
   input wire logic             a_rx_trig_hit_i,
   input wire logic             a_rx_timeout_i,
   // Outputs
   input wire logic             sel_a_o,
   input wire logic             sel_b_o,
   input wire logic             a_rx_block_ready_n_o,
   input wire logic             a_tx_block_ready_n_o,
   input wire logic             chan_a_irq_o,
   input wire logic [7:0]       a_line_status_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic fen;
   logic blk;
   logic tx_empty;
   logic tx_room;
   assign fen = a_fifo_ctrl_i[FIFO_CTRL_EN_BIT];
   assign blk = fen && a_fifo_ctrl_i[FIFO_CTRL_BLK_BIT];
   assign tx_empty = (a_tx_count_i == 0) && !a_tx_busy_i;
   assign tx_room = a_tx_count_i < FIFO_DEPTH;
   // ----
   // Select pins held long enough to pass the synchronisers; FIFO-on transmit ready, interrupt and line status
   // ----
   sequence only_a_s; (bus_style_i && !chan_a_select_n_i && chan_b_select_n_i) [*5]; endsequence
   sequence dual_s; (bus_style_i && !chan_a_select_n_i && !chan_b_select_n_i) [*5]; endsequence
   sequence idle_s; (bus_style_i && chan_a_select_n_i && chan_b_select_n_i) [*5]; endsequence
   sequence line_b_s; (!bus_style_i && !chan_a_select_n_i && channel_address_bit_i) [*5]; endsequence
   pick_a_a: assert property (only_a_s |-> sel_a_o && !sel_b_o)
      else $error("Channel A select wrong");
   pick_both_a: assert property (dual_s |-> sel_a_o && sel_b_o)
      else $error("Dual select wrong");
   pick_none_a: assert property (idle_s |-> !sel_a_o && !sel_b_o)
      else $error("Idle select wrong");
   pick_line_a: assert property (line_b_s |-> sel_b_o && !sel_a_o)
      else $error("Line mode select wrong");
   tx_single_a: assert property (fen && !blk |=>
      a_tx_block_ready_n_o == ($past(a_tx_count_i) != 0)) else $error("Single tx ready wrong");
   tx_block_a: assert property (blk |=>
      a_tx_block_ready_n_o == ($past(a_tx_count_i) == FIFO_DEPTH)) else $error("Block tx ready wrong");
   tx_irq_a: assert property (fen |=>
      chan_a_irq_o == ($past(a_tx_count_i) <= $past(a_tx_trig_i))) else $error("Tx irq wrong");
   line_stat_a: assert property (fen |=>
      a_line_status_o == {1'b0, $past(tx_empty), $past(tx_room), 5'h00}) else $error("Status wrong");
   // ----
   // Receive ready and FIFO-off transmit ready
   // ----
   sequence rx_event_s; blk && (a_rx_trig_hit_i || a_rx_timeout_i); endsequence
   sequence rx_drained_s; blk && !a_rx_trig_hit_i && !a_rx_timeout_i && a_rx_count_i == 0;
   endsequence
   rx_fall_a: assert property (rx_event_s |=> !a_rx_block_ready_n_o)
      else $error("Block rx ready did not fall");
   rx_rise_a: assert property (rx_drained_s |=> a_rx_block_ready_n_o)
      else $error("Block rx ready did not rise");
   rx_single_a: assert property (!blk |=>
      a_rx_block_ready_n_o == ($past(a_rx_count_i) == 0)) else $error("Single rx ready wrong");
   tx_nofifo_a: assert property (!fen |=>
      a_tx_block_ready_n_o == ($past(a_tx_count_i) != 0)) else $error("Holding tx ready wrong");
endmodule
bind duart_host_select duart_host_checker chk (
   .clk_i, .rst_i, .bus_style_i, .chan_a_select_n_i, .chan_b_select_n_i,
   .channel_address_bit_i, .a_fifo_ctrl_i, .a_tx_trig_i, .a_tx_count_i, .a_tx_busy_i,
   .a_rx_count_i, .a_rx_trig_hit_i, .a_rx_timeout_i, .a_rx_block_ready_n_o,
   .sel_a_o, .sel_b_o, .a_tx_block_ready_n_o, .chan_a_irq_o, .a_line_status_o);
`default_nettype wire

// *** host_model.sv ***
// Host processor pin model for the parallel bus
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // Requested levels: style, select A, select B, address bit, read
   input  wire logic [4:0] req_i,
   // Bus pins in the same order
   output logic      [4:0] pin_o
);
   assign pin_o[4:1] = req_i[4:1];
   // No read while both strobe selects are low
   assign pin_o[0] = req_i[0] && !(req_i[4] && req_i[3:2] == 2'b00);
endmodule
`default_nettype wire

// *** duart_host_select_test.sv ***
// Self-checking bench for select, identity and status pins
`timescale 1ns/100ps
`default_nettype none
module duart_host_select_test;
   import duart_host_pkg::*;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic [4:0]       req   = 5'h1C;
   logic [7:0]       dl    = 8'h01;
   logic [7:0]       dh    = 8'h00;
   logic [7:0]       fc    = 8'h00;
   logic [CNT_W-1:0] trg   = 5'h00;
   logic [CNT_W-1:0] rxc   = 5'h00;
   logic [CNT_W-1:0] txc   = 5'h00;
   logic             hit   = 1'b0;
   logic             tmo   = 1'b0;
   logic             busy  = 1'b0;
   logic [31:0]      r;
   logic [3:0]       st;
   logic [1:0]       s;
   logic             z;
   logic             rxe   = 1'b1;
   logic [15:0]      idr;
   logic [28:0]      got;
   wire logic [4:0]  pin;
   wire logic        sa, sb, iv, cr, rxa, txa, ia, rxb, txb, ib;
   wire logic [7:0]  idc, rev, lsa, lsb;
   logic [28:0]      notes[$];
   event             look;
   int               err_total   = 0;
   int               check_count = 0;
   int               seed        = 59262;
   host_model host (.req_i(req), .pin_o(pin));
   duart_host_select uut (
      .clk_i(clk_i), .rst_i(rst_i), .bus_style_i(pin[4]), .chan_a_select_n_i(pin[3]),
      .chan_b_select_n_i(pin[2]), .channel_address_bit_i(pin[1]), .rd_i(pin[0]),
      .a_div_low_i(dl), .a_div_high_i(dh), .a_fifo_ctrl_i(fc), .a_tx_trig_i(trg),
      .a_rx_count_i(rxc), .a_tx_count_i(txc), .a_rx_trig_hit_i(hit), .a_rx_timeout_i(tmo),
      .a_tx_busy_i(busy), .b_div_low_i(dl), .b_div_high_i(dh), .b_fifo_ctrl_i(fc),
      .b_tx_trig_i(trg), .b_rx_count_i(rxc), .b_tx_count_i(txc), .b_rx_trig_hit_i(hit),
      .b_rx_timeout_i(tmo), .b_tx_busy_i(busy), .chip_reset_o(cr), .sel_a_o(sa),
      .sel_b_o(sb), .ident_visible_o(iv), .ident_code_reg_o(idc), .revision_reg_o(rev),
      .a_rx_block_ready_n_o(rxa), .a_tx_block_ready_n_o(txa), .chan_a_irq_o(ia),
      .a_line_status_o(lsa), .b_rx_block_ready_n_o(rxb), .b_tx_block_ready_n_o(txb),
      .chan_b_irq_o(ib), .b_line_status_o(lsb));
   initial forever #5 clk_i = ~clk_i;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic note(input logic [28:0] e);
      notes.push_back(e);
      ->look;
   endtask
   task automatic verify(input logic ok);
      check_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("BAD %0t reset pin or reset value", $time);
      end
   endtask
   task automatic pulse(input int n, input logic e);
      logic seen;
      seen = 1'b0;
      rst_i = 1'b1;
      for (int i = 0; i < n + 12; i++) begin
         if (i == n) rst_i = 1'b0;
         tick(1);
         seen = seen | (cr === 1'b1);
      end
      verify(seen === e);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(look) begin
      got = {idc, rev, txa, ia, lsa[6:5], txb, ib, lsb[6:5], sa, sb, iv, rxa, rxb};
      check_count++;
      if (got !== notes.pop_front()) begin
         err_total++;
         $display("BAD %0t select, identity or status", $time);
      end
   end
   // ----
   // Stimulus
   // ----
   initial begin
      tick(5);
      note(29'h0000663);
      verify(rxa === 1'b1 && rxb === 1'b1 && lsa === 8'h60);
      rst_i = 1'b0;
      for (int i = 0; i < 60; i++) begin
         r = $random(seed);
         req = r[4:0];
         fc = {4'h0, r[5], 2'b00, r[15]};
         txc = r[10:6] % 5'd17;
         trg = {1'b0, r[14:11]};
         busy = r[16];
         dl = r[17] ? 8'h00 : r[25:18];
         dh = r[26] ? 8'h00 : {7'h00, r[27]};
         hit = r[28];
         rxc = {2'b00, r[31:29]};
         tmo = r[29] ^ r[30];
         st = {(fc[3] && fc[0]) ? (txc == FIFO_DEPTH) : (txc != 0),
               fc[0] ? (txc <= trg) : (txc == 0),
               txc == 0 && !busy,
               fc[0] ? (txc < 16) : (txc == 0)};
         z = dl == 8'h00 && dh == 8'h00;
         s = req[4] ? {!req[3], !req[2]} : {!req[3] && !req[1], !req[3] && req[1]};
         idr = z ? {IDENT_CODE_VAL, REVISION_VAL} : 16'h0000;
         // Block receive ready holds its level between trigger and empty
         if (fc[3] && fc[0])
            rxe = (hit || tmo) ? 1'b0 : ((rxc == 0) ? 1'b1 : rxe);
         else
            rxe = (rxc == 0);
         tick(6);
         note({idr, st, st, s, z, rxe, rxe});
      end
      req = 5'h00;
      tick(12);
      verify(cr === 1'b1);
      req = 5'h1C;
      tick(12);
      verify(cr === 1'b0);
      pulse(3, 1'b0);
      pulse(6, 1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
